// ==== design/alcm_regs.svh ====
`ifndef ALCM_REGS_SVH
`define ALCM_REGS_SVH

// Cell geometry
`define ALCM_NUM_FLOPS    4
`define ALCM_LUT6_BITS    64
`define ALCM_LUT4_BITS    16

// Lookup mask field positions inside a 64-bit half mask
`define ALCM_L4_LO_LSB    0
`define ALCM_L4_HI_LSB    16

// Route select field positions
`define ALCM_RSEL_FLOP    2

// Reset and constant values
`define ALCM_Q_RESET      1'b0
`define ALCM_CHAIN_CIN    1'b0
`define ALCM_SYNC_RESET   2'h3

// Clock select code that parks a flop
`define ALCM_CLK_OFF      2'h3

`endif

// ==== design/alcm_pkg.sv ====
package alcm_pkg;

    typedef enum logic [1:0] {
        ALCM_NORMAL,
        ALCM_EXTENDED,
        ALCM_ARITH,
        ALCM_SHARED
    } alcm_mode_e;

    typedef logic [1:0] alcm_clk_sel_t;

endpackage

// ==== design/alcm_flop_if.sv ====
`timescale 1ns/1ns
interface alcm_flop_if;
    logic d;
    logic ena;
    logic sclr;
    logic sload;
    logic ld_data;
    logic dclr;
    logic q;

    modport drv  (output d, output ena, output sclr, output sload, output ld_data,
                  output dclr, input q);
    modport flop (input d, input ena, input sclr, input sload, input ld_data,
                  input dclr, output q);
endinterface

// ==== design/alcm_flop.sv ====
`timescale 1ns/1ns
`include "alcm_regs.svh"
module alcm_flop (
    // Clock and reset
    input  logic            core_clk,
    input  logic            rst_n,
    // Control and data
    alcm_flop_if.flop       fif
);
    logic q_q;

    // Device clear first, then clear, then load, then enabled capture
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_q <= `ALCM_Q_RESET;
        end else if (fif.dclr) begin
            q_q <= `ALCM_Q_RESET;
        end else if (fif.sclr) begin
            q_q <= `ALCM_Q_RESET;
        end else if (fif.sload) begin
            q_q <= fif.ld_data;
        end else if (fif.ena) begin
            q_q <= fif.d;
        end
    end

    assign fif.q = q_q;
endmodule

// ==== design/alcm_cell.sv ====
`timescale 1ns/1ns
`include "alcm_regs.svh"
module alcm_cell (
    // Clock and reset
    input  logic                      core_clk,
    input  logic                      nrst,
    // Local interconnect data inputs
    input  logic                      in_a,
    input  logic                      in_b,
    input  logic                      in_c,
    input  logic                      in_d,
    input  logic                      in_e0,
    input  logic                      in_e1,
    input  logic                      in_f0,
    input  logic                      in_f1,
    // Cluster-wide controls
    input  logic [2:0]                cluster_clk_ena,
    input  logic                      cluster_sclr,
    input  logic                      cluster_sload,
    input  logic [1:0]                cluster_aclr_n,
    input  logic                      device_wide_clear_n,
    // Mode and lookup configuration
    input  alcm_pkg::alcm_mode_e      mode,
    input  logic [63:0]               lut_mask_top,
    input  logic [63:0]               lut_mask_bot,
    input  logic                      six_single,
    input  logic                      six_pair_sel,
    input  logic                      six_dup,
    input  logic                      ext_f1_sel,
    input  logic                      fb_en,
    input  logic [1:0]                fb_sel,
    input  logic                      carry_only,
    input  logic                      cnt_en,
    // Chain configuration
    input  logic                      carry_start,
    input  logic                      carry_bypass,
    input  logic                      share_start,
    input  logic                      share_bypass,
    // Flop configuration
    input  logic [3:0]                flop_src_sel,
    input  logic [3:0]                pack_pick,
    input  logic [3:0]                sclr_en,
    input  logic [3:0]                sload_en,
    input  logic [7:0]                clk_sel,
    input  logic [3:0]                aclr_sel,
    input  logic                      dev_clr_en,
    // Output routing configuration
    input  logic [2:0]                route_sel_0,
    input  logic [2:0]                route_sel_1,
    // Chain links to neighbouring cells
    input  logic                      carry_in,
    input  logic                      share_in,
    output logic                      carry_out,
    output logic                      share_out,
    // Results
    output logic [1:0]                comb_out,
    output logic [3:0]                reg_out,
    output logic                      route_out_0,
    output logic                      route_out_1,
    output logic                      carry_route_q
);

    function automatic logic lut6(input logic [63:0] m, input logic [5:0] i);
        lut6 = m[i];
    endfunction

    function automatic logic lut4(input logic [15:0] m, input logic [3:0] i);
        lut4 = m[i];
    endfunction

    logic [1:0] dclr_sync_q;
    logic       dev_clr;
    logic [3:0] q;
    logic       d_eff;
    logic [3:0] idx4;
    logic [5:0] idx_top;
    logic [5:0] idx_bot;
    logic [5:0] idx_p0;
    logic [5:0] idx_p1;
    logic [5:0] idx_ext;
    logic       res_top;
    logic       res_bot;
    logic       opa_t;
    logic       opb_t;
    logic       opa_b;
    logic       opb_b;
    logic       cin;
    logic       c_mid;
    logic       c_fin;
    logic       sum_t;
    logic       sum_b;
    logic       sh_in;
    logic       sh_mid;
    logic       sh_fin;
    logic       is_arith;

    // Pin crosses into core_clk domain before use
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dclr_sync_q <= `ALCM_SYNC_RESET;
        end else begin
            dclr_sync_q <= {dclr_sync_q[0], device_wide_clear_n};
        end
    end

    assign dev_clr = dev_clr_en & ~dclr_sync_q[1];

    // Flop fed back in place of in_d
    assign d_eff = fb_en ? q[fb_sel] : in_d;

    assign idx4    = {d_eff, in_c, in_b, in_a};
    assign idx_top = {in_f0, in_e0, idx4};
    assign idx_bot = {in_f1, in_e1, idx4};
    assign idx_p0  = {in_f1, in_e0, idx4};
    assign idx_p1  = {in_f0, in_e1, idx4};
    assign idx_ext = {in_e1, in_e0, idx4};
    assign is_arith = (mode == alcm_pkg::ALCM_ARITH);

    // Chain heads take a constant rather than a stray neighbour
    assign cin   = carry_start ? `ALCM_CHAIN_CIN : carry_in;
    assign sh_in = share_start ? `ALCM_CHAIN_CIN : share_in;

    // Lookups and adders
    always_comb begin
        res_top = 1'b0;
        res_bot = 1'b0;
        opa_t   = 1'b0;
        opb_t   = 1'b0;
        opa_b   = 1'b0;
        opb_b   = 1'b0;
        sum_t   = 1'b0;
        sum_b   = 1'b0;
        c_mid   = cin;
        c_fin   = cin;
        sh_mid  = sh_in;
        sh_fin  = sh_in;
        unique case (mode)
            alcm_pkg::ALCM_NORMAL: begin
                if (!six_single) begin
                    res_top = lut6(lut_mask_top, idx_top);
                    res_bot = lut6(lut_mask_bot, idx_bot);
                end else if (!six_pair_sel) begin
                    res_top = lut6(lut_mask_top, idx_p0);
                    res_bot = six_dup ? lut6(lut_mask_top, idx_p1) : res_top;
                end else begin
                    res_bot = lut6(lut_mask_bot, idx_p1);
                    res_top = six_dup ? lut6(lut_mask_bot, idx_p0) : res_bot;
                end
            end
            alcm_pkg::ALCM_EXTENDED: begin
                // Seventh input picks between the two six-input halves
                if (ext_f1_sel) begin
                    res_top = in_f1 ? lut6(lut_mask_top, idx_ext)
                                    : lut6(lut_mask_bot, idx_ext);
                end else begin
                    res_top = in_f0 ? lut6(lut_mask_top, idx_ext)
                                    : lut6(lut_mask_bot, idx_ext);
                end
                res_bot = res_top;
            end
            alcm_pkg::ALCM_ARITH: begin
                opa_t = lut4(lut_mask_top[`ALCM_L4_LO_LSB +: `ALCM_LUT4_BITS], idx4);
                opb_t = lut4(lut_mask_top[`ALCM_L4_HI_LSB +: `ALCM_LUT4_BITS], idx4);
                opa_b = lut4(lut_mask_bot[`ALCM_L4_LO_LSB +: `ALCM_LUT4_BITS], idx4);
                opb_b = lut4(lut_mask_bot[`ALCM_L4_HI_LSB +: `ALCM_LUT4_BITS], idx4);
                if (cnt_en) begin
                    // Counter: own flops plus all-ones when counting down
                    opa_t = q[0];
                    opa_b = q[2];
                    opb_t = in_e1;
                    opb_b = in_e1;
                end
                opb_t = opb_t ^ in_e0;
                opb_b = opb_b ^ in_e0;
                sum_t = opa_t ^ opb_t ^ cin;
                c_mid = (opa_t & opb_t) | (cin & (opa_t ^ opb_t));
                sum_b = opa_b ^ opb_b ^ c_mid;
                c_fin = (opa_b & opb_b) | (c_mid & (opa_b ^ opb_b));
                // Carry-only use hands out the lookups, sums unused
                res_top = carry_only ? opa_t : sum_t;
                res_bot = carry_only ? opa_b : sum_b;
            end
            alcm_pkg::ALCM_SHARED: begin
                opa_t  = lut4(lut_mask_top[`ALCM_L4_LO_LSB +: `ALCM_LUT4_BITS], idx4);
                sh_mid = lut4(lut_mask_top[`ALCM_L4_HI_LSB +: `ALCM_LUT4_BITS], idx4);
                opa_b  = lut4(lut_mask_bot[`ALCM_L4_LO_LSB +: `ALCM_LUT4_BITS],
                              {in_f1, in_e1, in_f0, in_e0});
                sh_fin = lut4(lut_mask_bot[`ALCM_L4_HI_LSB +: `ALCM_LUT4_BITS],
                              {in_f1, in_e1, in_f0, in_e0});
                sum_t = opa_t ^ sh_in ^ cin;
                c_mid = (opa_t & sh_in) | (cin & (opa_t ^ sh_in));
                sum_b = opa_b ^ sh_mid ^ c_mid;
                c_fin = (opa_b & sh_mid) | (c_mid & (opa_b ^ sh_mid));
                res_top = sum_t;
                res_bot = sum_b;
            end
        endcase
    end

    // Outside the adder modes the chains pass straight through
    assign carry_out = (carry_bypass || !(is_arith || mode == alcm_pkg::ALCM_SHARED))
                       ? carry_in : c_fin;
    assign share_out = (share_bypass || mode != alcm_pkg::ALCM_SHARED)
                       ? share_in : sh_fin;

    // Final carry also offered to the interconnect
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            carry_route_q <= `ALCM_Q_RESET;
        end else begin
            carry_route_q <= carry_out;
        end
    end

    alcm_flop_if fif [`ALCM_NUM_FLOPS] ();

    genvar g;
    generate
        for (g = 0; g < `ALCM_NUM_FLOPS; g = g + 1) begin : g_flop
            logic hi_half;
            logic pack;
            logic clk_ena;
            logic ctl_ena;
            logic rst_n;

            assign hi_half = (g >= 2);

            // Free pairing input per half
            always_comb begin
                if (mode == alcm_pkg::ALCM_EXTENDED) begin
                    pack = hi_half ? in_f1 : in_f0;
                end else if (hi_half) begin
                    pack = pack_pick[g] ? in_f0 : in_e1;
                end else begin
                    pack = pack_pick[g] ? in_f1 : in_e0;
                end
            end

            // Park code stops the flop like a gated clock
            assign clk_ena = (clk_sel[2*g +: 2] == `ALCM_CLK_OFF) ? 1'b0
                             : cluster_clk_ena[clk_sel[2*g +: 2]];

            // Arith flops also obey the local enables
            assign ctl_ena = !is_arith ? 1'b1
                             : (in_f1 & ((cnt_en && (g % 2 == 0)) ? in_f0 : 1'b1));

            // Async clear picked from the two cluster clears
            assign rst_n = nrst & cluster_aclr_n[aclr_sel[g]];

            assign fif[g].d       = flop_src_sel[g] ? pack : (hi_half ? res_bot : res_top);
            assign fif[g].ena     = clk_ena & ctl_ena;
            // Stopped clock also blocks sync clear and load
            assign fif[g].sclr    = cluster_sclr & sclr_en[g] & clk_ena;
            assign fif[g].sload   = cluster_sload & sload_en[g] & clk_ena;
            assign fif[g].ld_data = pack;
            assign fif[g].dclr    = dev_clr;
            assign q[g]           = fif[g].q;

            alcm_flop u_flop (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .fif      (fif[g])
            );
        end
    endgenerate

    assign reg_out  = q;
    assign comb_out = {res_bot, res_top};

    // Each route output picks a result or a flop
    assign route_out_0 = route_sel_0[`ALCM_RSEL_FLOP] ? q[route_sel_0[1:0]]
                         : (route_sel_0[0] ? res_bot : res_top);
    assign route_out_1 = route_sel_1[`ALCM_RSEL_FLOP] ? q[route_sel_1[1:0]]
                         : (route_sel_1[0] ? res_bot : res_top);

endmodule

// ==== verification/alcm_cell_sva.sv ====
`timescale 1ns/1ns
module alcm_cell_sva (
    // Clock and reset
    input logic                 core_clk,
    input logic                 nrst,
    // Inputs
    input logic                 in_e0,
    input logic                 in_f1,
    input logic [2:0]           cluster_clk_ena,
    input logic                 cluster_sclr,
    input logic                 cluster_sload,
    input logic [1:0]           cluster_aclr_n,
    input logic                 device_wide_clear_n,
    input alcm_pkg::alcm_mode_e mode,
    input logic                 dev_clr_en,
    input logic [3:0]           flop_src_sel,
    input logic [3:0]           pack_pick,
    input logic [3:0]           sclr_en,
    input logic [7:0]           clk_sel,
    input logic [2:0]           route_sel_0,
    input logic                 carry_in,
    input logic                 share_in,
    // Outputs
    input logic                 carry_out,
    input logic                 share_out,
    input logic [1:0]           comb_out,
    input logic [3:0]           reg_out,
    input logic                 route_out_0,
    input logic                 carry_route_q
);
    logic [3:0] run;
    logic       calm;
    logic       pk0;
    logic       nrm;

    always_comb begin
        for (int n = 0; n < 4; n++) begin
            run[n] = clk_sel[2*n +: 2] != 2'h3 && cluster_clk_ena[clk_sel[2*n +: 2]];
        end
    end
    // Device clear, async clears and loads are excluded; sync clear is left to each check
    assign calm = !dev_clr_en && device_wide_clear_n && cluster_aclr_n == 2'h3 && !cluster_sload;
    assign pk0  = pack_pick[0] ? in_f1 : in_e0;
    assign nrm  = mode == alcm_pkg::ALCM_NORMAL;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_route_flop: assert property (
        route_sel_0[2] |-> route_out_0 == reg_out[route_sel_0[1:0]])
        else $error("route_out_0 not the chosen flop");
    a_chain_pass: assert property (
        !mode[1] |-> carry_out == carry_in && share_out == share_in)
        else $error("chain not passed through outside arithmetic");
    a_carry_reg: assert property (
        nrst && $past(nrst) |-> carry_route_q == $past(carry_out))
        else $error("registered carry wrong");
    a_parked_hold: assert property (
        calm && !cluster_sclr && !run[2] |=> $stable(reg_out[2]) || cluster_aclr_n != 2'h3)
        else $error("stopped flop moved");
    a_pack_capture: assert property (
        calm && !cluster_sclr && run[0] && flop_src_sel[0] && nrm |=> reg_out[0] == $past(pk0))
        else $error("packed input not captured");
    a_lookup_capture: assert property (
        calm && !cluster_sclr && run[3] && !flop_src_sel[3] && nrm |=> reg_out[3] == $past(comb_out[1]))
        else $error("lookup result not captured");
    a_sync_clear: assert property (
        calm && cluster_sclr && sclr_en[0] && run[0] && nrm |=> !reg_out[0])
        else $error("sync clear ignored");
    a_dev_clear: assert property (
        (dev_clr_en && !device_wide_clear_n)[*3] |=> reg_out == 4'h0)
        else $error("device clear ignored");
endmodule

bind alcm_cell alcm_cell_sva alcm_cell_sva_i (.*);

// ==== verification/alcm_chain_nbr.sv ====
`timescale 1ns/1ns
// Previous cell on both chains: a half adder on its own two inputs
module alcm_chain_nbr (
    input  logic nx,
    input  logic ny,
    output logic carry_in,
    output logic share_in
);
    assign carry_in = nx & ny;
    assign share_in = nx ^ ny;
endmodule

// ==== verification/alcm_cell_tb.sv ====
`timescale 1ns/1ns
module alcm_cell_tb;
    logic core_clk, nrst, in_a, in_b, in_c, in_d, in_e0, in_e1, in_f0, in_f1, nx, ny;
    logic cluster_sclr, cluster_sload, device_wide_clear_n, dev_clr_en, six_single;
    logic six_pair_sel, six_dup, ext_f1_sel, fb_en, carry_only, cnt_en, carry_start;
    logic carry_bypass, share_start, share_bypass, carry_in, share_in, carry_out;
    logic share_out, route_out_0, route_out_1, carry_route_q, at, bt, ab, bb, c0, sh;
    logic [1:0] cluster_aclr_n, fb_sel, comb_out;
    logic [2:0] cluster_clk_ena, route_sel_0, route_sel_1;
    logic [3:0] flop_src_sel, pack_pick, sclr_en, sload_en, aclr_sel, reg_out, q;
    logic [7:0] clk_sel;
    logic [31:0] rs, r;
    logic [63:0] lut_mask_top, lut_mask_bot;
    alcm_pkg::alcm_mode_e mode;
    int err_total, total_checks, t0, t1;

    alcm_cell alcm_cell_i (.*);
    alcm_chain_nbr alcm_chain_nbr_i (.*);

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // Packed pin feeding flop n; extended mode fixes the pairing
    function automatic logic pk(int n);
        if (mode == alcm_pkg::ALCM_EXTENDED) return n < 2 ? in_f0 : in_f1;
        return n < 2 ? (pack_pick[n] ? in_f1 : in_e0) : (pack_pick[n] ? in_f0 : in_e1);
    endfunction

    // Masks all-ones on top, all-zeros below, so the lookups read 1 and 0
    function automatic logic rt(logic [2:0] s);
        return s[2] ? q[s[1:0]] : !s[0];
    endfunction

    task automatic chk(string nm, logic [3:0] got, logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Tests need about 350 cycles
    initial begin
        #80000;
        err_total++;
        results();
    end

    initial begin
        rs = 32'h47;
        {in_a, in_b, in_c, in_d, in_e0, in_e1, in_f0, in_f1, nx, ny, q} = '0;
        {cluster_sclr, cluster_sload, dev_clr_en, six_single, six_pair_sel, six_dup} = '0;
        {ext_f1_sel, fb_en, fb_sel, carry_only, cnt_en, carry_start, carry_bypass} = '0;
        {share_start, share_bypass, route_sel_0, route_sel_1, flop_src_sel} = '0;
        {pack_pick, sclr_en, sload_en, aclr_sel, clk_sel} = '0;
        {cluster_clk_ena, cluster_aclr_n, device_wide_clear_n} = 6'h3f;
        lut_mask_top = '1;
        lut_mask_bot = '0;
        mode = alcm_pkg::ALCM_NORMAL;
        nrst = 1'b0;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        chk("reg_out", reg_out, 4'h0);
        $display("reset test done");
        // First edge after release loads the lookups: low flops 1, high 0
        q = 4'h3;
        for (int m = 0; m < 2; m++) begin
            repeat (40) begin
                @(negedge core_clk);
                chk("reg_out", reg_out, q);
                mode = m ? alcm_pkg::ALCM_EXTENDED : alcm_pkg::ALCM_NORMAL;
                r = rnd();
                {in_a, in_b, in_c, in_d, in_e0, in_e1, in_f0, in_f1} = r[7:0];
                {pack_pick, cluster_clk_ena, fb_en, fb_sel, nx, ny} = r[19:8];
                {clk_sel, route_sel_0, route_sel_1} = r[31:18];
                route_sel_0[2] = route_sel_0[2] | m[0];
                route_sel_1[2] = route_sel_1[2] | m[0];
                flop_src_sel = m ? 4'hf : r[3:0] ^ r[27:24];
                {sclr_en, sload_en} = r[27:20];
                #1;
                chk("carry_out", carry_out, nx & ny);
                chk("route_out_0", route_out_0, rt(route_sel_0));
                chk("route_out_1", route_out_1, rt(route_sel_1));
                if (!m) chk("comb_out", comb_out, 4'h1);
                else chk("comb_out", comb_out, {2{in_f0}});
                for (int n = 0; n < 4; n++) begin
                    if (clk_sel[2*n +: 2] != 2'h3 && cluster_clk_ena[clk_sel[2*n +: 2]]) begin
                        q[n] = flop_src_sel[n] ? pk(n) : n < 2;
                    end
                end
            end
            $display("packing test done");
        end
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 128; i++) begin
                @(negedge core_clk);
                mode = m ? alcm_pkg::ALCM_SHARED : alcm_pkg::ALCM_ARITH;
                r = rnd();
                {at, bt, ab, bb, in_e0, nx, ny} = i[6:0];
                {in_a, in_b, in_c, in_d, in_e1, in_f0, in_f1, carry_start, share_start} = r[8:0];
                {six_single, six_pair_sel, six_dup, ext_f1_sel} = r[12:9];
                carry_only = r[13];
                lut_mask_top = {32'h0, {16{bt}}, {16{at}}};
                lut_mask_bot = {32'h0, {16{bb}}, {16{ab}}};
                #1;
                c0 = carry_start ? 1'b0 : nx & ny;
                sh = share_start ? 1'b0 : nx ^ ny;
                if (m) begin
                    t0 = at + sh + c0;
                    t1 = ab + bt + t0[1];
                    chk("share_out", share_out, bb);
                end else begin
                    t0 = at + (bt ^ in_e0) + c0;
                    t1 = ab + (bb ^ in_e0) + t0[1];
                    chk("share_out", share_out, nx ^ ny);
                end
                chk("comb_out", comb_out, (!m && carry_only) ? {ab, at} : {t1[0], t0[0]});
                chk("carry_out", carry_out, t1[1]);
            end
            $display("arithmetic test done");
        end
        @(negedge core_clk);
        mode = alcm_pkg::ALCM_NORMAL;
        lut_mask_top = '1;
        lut_mask_bot = '0;
        {flop_src_sel, pack_pick, sclr_en, clk_sel} = 20'hf0524;
        {cluster_clk_ena, in_e0, in_e1} = 5'h1f;
        repeat (2) @(negedge core_clk);
        chk("reg_out", reg_out, 4'hf);
        cluster_sclr = 1'b1;
        @(negedge core_clk);
        chk("reg_out", reg_out, 4'ha);
        {cluster_sclr, dev_clr_en, device_wide_clear_n} = 3'b010;
        repeat (2) @(negedge core_clk);
        chk("reg_out", reg_out, 4'hf);
        @(negedge core_clk);
        chk("reg_out", reg_out, 4'h0);
        device_wide_clear_n = 1'b1;
        repeat (4) @(negedge core_clk);
        dev_clr_en = 1'b0;
        {aclr_sel, cluster_aclr_n} = 6'h09;
        #1;
        chk("reg_out", reg_out, 4'hd);
        cluster_aclr_n = 2'h3;
        // Load takes the packed pins over the lookup results
        {cluster_sload, sload_en, in_e0, flop_src_sel} = 10'h3e0;
        @(negedge core_clk);
        chk("reg_out", reg_out, 4'hc);
        cluster_sload = 1'b0;
        $display("clear test done");
        results();
    end
endmodule
